// ### rtl/rsr_readout.sv
`timescale 1ns/1ps
`default_nettype none
module rsr_readout
    import rsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic core_ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pix_clk,
    input wire logic vertical_sync_input,
    output logic frame_valid,
    output logic line_valid,
    output logic pix_valid,
    output logic [1:0] line_kind,
    output logic [12:0] pix_col,
    output logic [12:0] pix_row,
    output logic frame_invalid,
    output logic frame_start
);
    // Core-domain state: registers, bus answer, snapshot handshake
    typedef struct packed {
        logic crop_en;
        logic [N_TUNE-1:0][7:0] tune;
        logic [1:0] decim;
        logic [12:0] ob_w;
        logic [12:0] fi_w;
        logic [23:0] frame_line_total;
        logic [15:0] line_clock_total;
        logic [1:0] rate;
        logic [7:0] rwt;
        logic [7:0] twt;
        logic [7:0] settle;
        logic master;
        logic [N_AREA-1:0][3:0][12:0] area;
        logic chg;
        logic [31:0] prdata;
        logic slverr;
        logic req1;
        logic req2;
        logic req3;
        logic inv1;
        logic inv2;
        logic ack;
        rsr_cfg_t xfer;
    } rsr_core_t;

    // Link-domain state: frame and line timing, active and pending configs
    typedef struct packed {
        logic vs1;
        logic vs2;
        logic vs3;
        logic ack1;
        logic ack2;
        logic ack3;
        logic req;
        logic master;
        logic [15:0] line_clock_total;
        logic [23:0] frame_line_total;
        rsr_cfg_t act;
        rsr_cfg_t pend;
        logic have_pend;
        rsr_phase_t phase;
        logic [15:0] hcnt;
        logic [23:0] lcnt;
        logic [15:0] hdr_left;
        logic vs_pend;
        logic invalid;
        logic pix_valid;
        logic line_valid;
        logic frame_valid;
        rsr_kind_t kind;
        logic [12:0] col;
        logic [12:0] row;
        logic fstart;
    } rsr_link_t;

    localparam rsr_core_t CORE_RST = '{tune: RST_TUNE, ob_w: RST_OBW, fi_w: RST_FIW,
                                      frame_line_total: RST_FRAME_LINE_TOTAL, line_clock_total: RST_LINE_CLOCK_TOTAL, rate: RST_RATE,
                                      rwt: RST_RWT, twt: RST_TWT, settle: RST_SETTLE,
                                      master: 1'b1, xfer: CFG_RST, default: '0};
    // Request line starts high so the first snapshot is asked for right after reset
    localparam rsr_link_t LINK_RST = '{act: CFG_RST, pend: CFG_RST, phase: PH_TAIL,
                                      kind: K_BLANK, req: 1'b1, master: 1'b1,
                                      line_clock_total: RST_LINE_CLOCK_TOTAL, frame_line_total: RST_FRAME_LINE_TOTAL, default: '0};

    rsr_core_t c_q;
    rsr_core_t c_d;
    rsr_link_t l_q;
    rsr_link_t l_d;
    logic [1:0] lrst_s;
    logic [1:0] lce_s;
    logic lrst_n;
    logic lce;
    logic [9:0] idx;
    logic [15:0] hdr_live;
    logic [15:0] lpf;
    logic line_end;
    logic frame_go;
    rsr_cfg_t nxt;
    logic crop_on;
    logic sub_on;

    rsr_span_if hsp();
    rsr_span_if vsp();

    // Decode shared by the error answer and the unmapped-access assertion
    function automatic logic is_mapped(input logic [9:0] a);
        logic hit;
        hit = (a >= IDX_AREA_BASE) && (a < IDX_AREA_END);
        for (int t = 0; t < N_TUNE; t++) begin
            if (a == IDX_TUNE[t]) begin
                hit = 1'b1;
            end
        end
        case (a)
            IDX_CROP_EN, IDX_DECIM, IDX_OBW, IDX_FIW, IDX_FRAME_LINE_TOTAL, IDX_LINE_CLOCK_TOTAL, IDX_RATE,
            IDX_RWT, IDX_TWT, IDX_SETTLE, IDX_CTRL, IDX_LPF, IDX_STAT: hit = 1'b1;
            default: ;
        endcase
        return hit;
    endfunction : is_mapped

    assign idx = paddr[11:2];
    assign pready = 1'b1;
    assign prdata = c_q.prdata;
    assign pslverr = c_q.slverr;

    // Fixed lines, shutter waits and settle lines plus all area heights give lines per frame
    always_comb begin
        hdr_live = 16'(FIXED_LINES + {8'h0, c_q.rwt} + {8'h0, c_q.twt} + {8'h0, c_q.settle});
        lpf = hdr_live;
        for (int a = 0; a < N_AREA; a++) begin
            lpf = 16'(lpf + {3'h0, c_q.area[a][F_VZ]});
        end
    end

    // Register file, bus slave and snapshot side of the handshake
    always_comb begin
        c_d = c_q;
        c_d.req1 = l_q.req;
        c_d.req2 = c_q.req1;
        c_d.req3 = c_q.req2;
        c_d.inv1 = l_q.invalid;
        c_d.inv2 = c_q.inv1;
        // Link asked for a snapshot; xfer then holds still until the next ask
        if (c_q.req2 != c_q.req3) begin
            c_d.xfer = '{crop_en: c_q.crop_en, decim: c_q.decim, master: c_q.master,
                         ob_w: c_q.ob_w, fi_w: c_q.fi_w, frame_line_total: c_q.frame_line_total,
                         line_clock_total: c_q.line_clock_total, hdr: hdr_live, area: c_q.area, chg: c_q.chg};
            c_d.chg = 1'b0;
            c_d.ack = ~c_q.ack;
        end
        // Read data and error captured in setup, shown through the access phase
        if (psel && !penable) begin
            c_d.slverr = !is_mapped(idx);
            c_d.prdata = 32'h0;
            case (idx)
                IDX_CROP_EN: c_d.prdata = {31'h0, c_q.crop_en};
                IDX_DECIM: c_d.prdata = {30'h0, c_q.decim};
                IDX_OBW: c_d.prdata = {19'h0, c_q.ob_w};
                IDX_FIW: c_d.prdata = {19'h0, c_q.fi_w};
                IDX_FRAME_LINE_TOTAL: c_d.prdata = {8'h0, c_q.frame_line_total};
                IDX_LINE_CLOCK_TOTAL: c_d.prdata = {16'h0, c_q.line_clock_total};
                IDX_RATE: c_d.prdata = {30'h0, c_q.rate};
                IDX_RWT: c_d.prdata = {24'h0, c_q.rwt};
                IDX_TWT: c_d.prdata = {24'h0, c_q.twt};
                IDX_SETTLE: c_d.prdata = {24'h0, c_q.settle};
                IDX_CTRL: c_d.prdata = {31'h0, c_q.master};
                IDX_LPF: c_d.prdata = {16'h0, lpf};
                IDX_STAT: c_d.prdata = {30'h0, c_q.chg, c_q.inv2};
                default: ;
            endcase
            for (int t = 0; t < N_TUNE; t++) begin
                if (idx == IDX_TUNE[t]) begin
                    c_d.prdata = {24'h0, c_q.tune[t]};
                end
            end
            if (idx >= IDX_AREA_BASE && idx < IDX_AREA_END) begin
                c_d.prdata = {19'h0, c_q.area[idx[4:2]][idx[1:0]]};
            end
        end
        // Writes land at the access edge; read-only words ignore them
        if (psel && penable && pwrite) begin
            case (idx)
                IDX_CROP_EN: c_d.crop_en = pwdata[0];
                IDX_DECIM: c_d.decim = pwdata[1:0];
                IDX_OBW: c_d.ob_w = pwdata[12:0];
                IDX_FIW: c_d.fi_w = pwdata[12:0];
                IDX_FRAME_LINE_TOTAL: c_d.frame_line_total = pwdata[23:0];
                IDX_LINE_CLOCK_TOTAL: c_d.line_clock_total = pwdata[15:0];
                IDX_RATE: c_d.rate = pwdata[1:0];
                IDX_RWT: c_d.rwt = pwdata[7:0];
                IDX_TWT: c_d.twt = pwdata[7:0];
                IDX_SETTLE: c_d.settle = pwdata[7:0];
                IDX_CTRL: c_d.master = pwdata[0];
                default: ;
            endcase
            for (int t = 0; t < N_TUNE; t++) begin
                if (idx == IDX_TUNE[t]) begin
                    c_d.tune[t] = pwdata[7:0];
                end
            end
            // Any area write marks the next snapshot as a changed one; set beats clear
            if (idx >= IDX_AREA_BASE && idx < IDX_AREA_END) begin
                c_d.area[idx[4:2]][idx[1:0]] = pwdata[12:0];
                c_d.chg = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            c_q <= CORE_RST;
        end else if (core_ce) begin
            c_q <= c_d;
        end
    end

    // Reset and enable brought into the pixel clock domain
    always_ff @(posedge pix_clk) begin
        lrst_s <= {lrst_s[0], resetn};
        lce_s <= {lce_s[0], core_ce};
    end
    assign lrst_n = lrst_s[1];
    assign lce = lce_s[1];

    // Line ends at the fixed line total whatever the crop
    assign line_end = ({1'b0, l_q.hcnt} + 17'h1) >= {1'b0, l_q.line_clock_total};
    // Frame starts by line total in master mode, by external sync in slave mode
    assign frame_go = line_end && (l_q.master ? ((l_q.lcnt + 24'h1) >= l_q.frame_line_total)
                                              : l_q.vs_pend);
    assign nxt = l_q.have_pend ? l_q.pend : l_q.act;
    assign crop_on = l_q.act.crop_en && (l_q.act.decim != DECIM_SUB);
    assign sub_on = (l_q.act.decim == DECIM_SUB);

    // Area lists for the walkers; without crop one full-array area
    generate
        for (genvar i = 0; i < N_AREA; i++) begin : g_span
            localparam bit FIRST = (i == 0);
            assign hsp.start[i] = crop_on ? l_q.act.area[i][F_HS] : (sub_on ? GB_COL : 13'h0);
            assign hsp.size[i] = crop_on ? l_q.act.area[i][F_HZ] : (FIRST ? ARRAY_W : 13'h0);
            assign vsp.start[i] = crop_on ? l_q.act.area[i][F_VS] : (sub_on ? GB_ROW : 13'h0);
            assign vsp.size[i] = crop_on ? l_q.act.area[i][F_VZ]
                                         : (FIRST ? 13'(ARRAY_H - (sub_on ? GB_ROW : 13'h0)) : 13'h0);
        end
    endgenerate
    assign hsp.step = sub_on ? STEP_SUB : STEP_FULL;
    assign vsp.step = sub_on ? STEP_SUB : STEP_FULL;
    // Columns restart every line and run from its first cycle
    assign hsp.restart = line_end;
    assign hsp.adv = (l_q.phase == PH_ROWS) && vsp.valid;
    // Rows restart at the frame and step once per image line
    assign vsp.restart = frame_go;
    assign vsp.adv = line_end && (l_q.phase == PH_ROWS);

    rsr_span_walker u_hwalk (
        .clk(pix_clk),
        .rst_n(lrst_n),
        .ce(lce),
        .sp(hsp.walk)
    );

    rsr_span_walker u_vwalk (
        .clk(pix_clk),
        .rst_n(lrst_n),
        .ce(lce),
        .sp(vsp.walk)
    );

    // Link timing: header lines, image rows, then blank tail to frame end
    always_comb begin
        d_init: begin
            l_d = l_q;
        end
        l_d.fstart = 1'b0;
        l_d.vs1 = vertical_sync_input;
        l_d.vs2 = l_q.vs1;
        l_d.vs3 = l_q.vs2;
        l_d.ack1 = c_q.ack;
        l_d.ack2 = l_q.ack1;
        l_d.ack3 = l_q.ack2;
        l_d.hcnt = line_end ? 16'h0 : 16'(l_q.hcnt + 16'h1);
        if (line_end) begin
            l_d.lcnt = 24'(l_q.lcnt + 24'h1);
            // Totals follow the registers from the next line on; a long reset frame
            // would otherwise hold off every new setting for about 800,000 cycles
            l_d.line_clock_total = nxt.line_clock_total;
            l_d.frame_line_total = nxt.frame_line_total;
            l_d.master = nxt.master;
            if (l_q.phase == PH_HDR) begin
                if (l_q.hdr_left == 16'h0) begin
                    l_d.phase = PH_ROWS;
                end else begin
                    l_d.hdr_left = 16'(l_q.hdr_left - 16'h1);
                end
            end
        end
        if (l_q.phase == PH_ROWS && !vsp.valid) begin
            l_d.phase = PH_TAIL;
        end
        // Area, crop and width settings take effect only here, so no frame mixes two area sets
        if (frame_go) begin
            l_d.act = nxt;
            l_d.have_pend = 1'b0;
            l_d.invalid = l_q.have_pend && l_q.pend.chg;
            l_d.lcnt = 24'h0;
            l_d.phase = PH_HDR;
            l_d.hdr_left = 16'(nxt.hdr - 16'h1);
            l_d.vs_pend = 1'b0;
            l_d.fstart = 1'b1;
        end
        // Snapshot arrived; held for the frame boundary, next one asked at once
        if (l_q.ack2 != l_q.ack3) begin
            l_d.pend = c_q.xfer;
            // Change mark survives refreshes until a frame boundary consumes it
            l_d.pend.chg = c_q.xfer.chg || (l_q.have_pend && l_q.pend.chg && !frame_go);
            l_d.have_pend = 1'b1;
            l_d.req = ~l_q.req;
        end
        // Sync edge is kept even when it meets the frame start that clears it
        if (l_q.vs2 && !l_q.vs3) begin
            l_d.vs_pend = 1'b1;
        end
        // Registered pixel outputs
        l_d.kind = K_BLANK;
        l_d.pix_valid = 1'b0;
        l_d.col = 13'h0;
        l_d.row = 13'h0;
        if (l_q.phase == PH_HDR) begin
            l_d.kind = (l_q.lcnt == 24'h0) ? K_INFO : K_OB;
            l_d.pix_valid = l_q.hcnt < {3'h0, (l_q.lcnt == 24'h0) ? l_q.act.fi_w : l_q.act.ob_w};
            l_d.col = l_q.hcnt[12:0];
            l_d.row = l_q.lcnt[12:0];
        end else if (l_q.phase == PH_ROWS && vsp.valid) begin
            l_d.kind = K_IMAGE;
            // Packed from cycle 0; the rest of the line stays blank
            l_d.pix_valid = hsp.valid;
            l_d.col = hsp.addr;
            l_d.row = vsp.addr;
        end
        l_d.line_valid = (l_d.kind != K_BLANK);
        l_d.frame_valid = (l_d.phase != PH_TAIL);
    end

    always_ff @(posedge pix_clk) begin
        if (!lrst_n) begin
            l_q <= LINK_RST;
        end else if (lce) begin
            l_q <= l_d;
        end
    end

    assign frame_valid = l_q.frame_valid;
    assign line_valid = l_q.line_valid;
    assign pix_valid = l_q.pix_valid;
    assign line_kind = l_q.kind;
    assign pix_col = l_q.col;
    assign pix_row = l_q.row;
    assign frame_invalid = l_q.invalid;
    assign frame_start = l_q.fstart;

    sequence s_apb_setup;
        psel && !penable;
    endsequence

    sequence s_new_frame;
        frame_go && lce;
    endsequence

    a_apb_unmapped_err: assert property (@(posedge core_clk) disable iff (!resetn)
        s_apb_setup and (core_ce && !is_mapped(idx)) |=> c_q.slverr)
        else $error("unmapped access not flagged");

    a_line_period_fixed: assert property (@(posedge pix_clk) disable iff (!lrst_n)
        line_end && l_q.hcnt != 16'h0 |-> l_q.hcnt == 16'(l_q.line_clock_total - 16'h1))
        else $error("line ended off the line total");

    a_left_justified: assert property (@(posedge pix_clk) disable iff (!lrst_n)
        $rose(l_q.pix_valid) && l_q.kind == K_IMAGE |-> $past(l_q.hcnt) == 16'h0)
        else $error("image pixels not left-justified");

    a_row_crop_start: assert property (@(posedge pix_clk) disable iff (!lrst_n)
        s_new_frame and (nxt.crop_en && nxt.decim != DECIM_SUB && nxt.area[0][F_VZ] != 13'h0)
        |=> vsp.addr == l_q.act.area[0][F_VS])
        else $error("first row not at crop start");

    a_one_invalid_frame: assert property (@(posedge pix_clk) disable iff (!lrst_n)
        s_new_frame and !l_q.have_pend |=> !l_q.invalid)
        else $error("invalid frame repeated without change");

    a_no_crop_sub: assert property (@(posedge pix_clk) disable iff (!lrst_n)
        l_q.act.decim == DECIM_SUB |-> hsp.size[1] == 13'h0 && hsp.step == STEP_SUB)
        else $error("crop active in subsampling");

    a_gb_first_row: assert property (@(posedge pix_clk) disable iff (!lrst_n)
        s_new_frame and nxt.decim == DECIM_SUB |=> vsp.addr == GB_ROW && hsp.start[0] == GB_COL)
        else $error("subsampled frame not on green-on-blue");

    a_cfg_at_frame: assert property (@(posedge pix_clk) disable iff (!lrst_n)
        $changed(l_q.act) |-> $past(frame_go))
        else $error("settings changed mid-frame");
endmodule : rsr_readout
`default_nettype wire

// ### rtl/rsr_pkg.sv
// Operation
// - Up to eight areas, origin first effective pixel
// - Crop rides all-pixel scan, line period fixed
// - Cropped pixels left-justified, remainder becomes blanking
// - Rows from crop start; frame by sync/total
// - Area change yields exactly one invalid frame
// - No crop while half subsampling selected
// - Subsampled frame starts on green-on-blue pixel
// - Frame lines are sizes, waits, settle lines, 86 lines
`default_nettype none
package rsr_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [9:0] IDX_CROP_EN = 10'h000;
    localparam logic [9:0] IDX_DECIM = 10'h03C;
    localparam logic [9:0] IDX_OBW = 10'h0D0;
    localparam logic [9:0] IDX_FIW = 10'h0D2;
    localparam logic [9:0] IDX_FRAME_LINE_TOTAL = 10'h0D4;
    localparam logic [9:0] IDX_LINE_CLOCK_TOTAL = 10'h0D8;
    localparam logic [9:0] IDX_RATE = 10'h0DC;
    localparam logic [9:0] IDX_RWT = 10'h0E2;
    localparam logic [9:0] IDX_TWT = 10'h0E3;
    localparam logic [9:0] IDX_SETTLE = 10'h0E6;
    localparam logic [9:0] IDX_CTRL = 10'h0F0;
    localparam logic [9:0] IDX_LPF = 10'h0F1;
    localparam logic [9:0] IDX_STAT = 10'h0F2;
    localparam logic [9:0] IDX_AREA_BASE = 10'h100;
    localparam logic [9:0] IDX_AREA_END = 10'h120;
    localparam int N_TUNE = 6;
    localparam logic [N_TUNE-1:0][9:0] IDX_TUNE = {10'h01B, 10'h019, 10'h018,
                                                  10'h016, 10'h015, 10'h014};
    localparam logic [N_TUNE-1:0][7:0] RST_TUNE = {8'h3A, 8'h04, 8'h40, 8'hB1, 8'h22, 8'h0A};
    // Area field order within one area's four words
    localparam int N_AREA = 8;
    localparam int F_HS = 0;
    localparam int F_HZ = 1;
    localparam int F_VS = 2;
    localparam int F_VZ = 3;
    localparam logic [3:0] AREA_NONE = 4'h8;
    // Reset values
    localparam logic [12:0] RST_OBW = 13'h09A8;
    localparam logic [12:0] RST_FIW = 13'h09A8;
    localparam logic [23:0] RST_FRAME_LINE_TOTAL = 24'h0008AA;
    localparam logic [15:0] RST_LINE_CLOCK_TOTAL = 16'h0167;
    localparam logic [1:0] RST_RATE = 2'h2;
    localparam logic [7:0] RST_RWT = 8'h06;
    localparam logic [7:0] RST_TWT = 8'h28;
    localparam logic [7:0] RST_SETTLE = 8'h12;
    // Array geometry and scan constants
    localparam logic [12:0] ARRAY_W = 13'h09A8;
    localparam logic [12:0] ARRAY_H = 13'h0810;
    localparam logic [15:0] FIXED_LINES = 16'h0056;
    localparam logic [12:0] GB_ROW = 13'h0001;
    localparam logic [12:0] GB_COL = 13'h0000;
    localparam logic [1:0] DECIM_SUB = 2'h1;
    localparam logic [1:0] STEP_FULL = 2'h1;
    localparam logic [1:0] STEP_SUB = 2'h2;
    localparam logic [15:0] RST_HDR = 16'h0096;
    typedef enum logic [1:0] {PH_HDR, PH_ROWS, PH_TAIL} rsr_phase_t;
    typedef enum logic [1:0] {K_BLANK, K_INFO, K_OB, K_IMAGE} rsr_kind_t;
    // Configuration snapshot handed to the link side on every request; totals and master applied at each line end, the rest once per frame
    typedef struct packed {
        logic crop_en;
        logic [1:0] decim;
        logic master;
        logic [12:0] ob_w;
        logic [12:0] fi_w;
        logic [23:0] frame_line_total;
        logic [15:0] line_clock_total;
        logic [15:0] hdr;
        logic [N_AREA-1:0][3:0][12:0] area;
        logic chg;
    } rsr_cfg_t;
    localparam rsr_cfg_t CFG_RST = '{master: 1'b1, ob_w: RST_OBW, fi_w: RST_FIW,
                                    frame_line_total: RST_FRAME_LINE_TOTAL, line_clock_total: RST_LINE_CLOCK_TOTAL, hdr: RST_HDR,
                                    default: '0};
endpackage : rsr_pkg
`default_nettype wire

// ### rtl/rsr_span_if.sv
`timescale 1ns/1ps
`default_nettype none
// One span walker: area list in, pixel or row address out
interface rsr_span_if;
    logic [7:0][12:0] start;
    logic [7:0][12:0] size;
    logic [1:0] step;
    logic restart;
    logic adv;
    logic [12:0] addr;
    logic valid;
    modport ctrl(output start, output size, output step, output restart, output adv,
                 input addr, input valid);
    modport walk(input start, input size, input step, input restart, input adv,
                 output addr, output valid);
endinterface : rsr_span_if
`default_nettype wire

// ### rtl/rsr_span_walker.sv
`timescale 1ns/1ps
`default_nettype none
module rsr_span_walker
    import rsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    rsr_span_if.walk sp
);
    typedef struct packed {
        logic [3:0] idx;
        logic [12:0] off;
    } rsr_walk_t;

    rsr_walk_t q;
    rsr_walk_t d;

    // Lowest area at or above lo with a nonzero size; empty areas cost no cycle
    function automatic logic [3:0] first_from(input logic [3:0] lo,
                                              input logic [7:0][12:0] sz);
        logic [3:0] r;
        r = AREA_NONE;
        for (int i = N_AREA - 1; i >= 0; i--) begin
            if (i >= int'(lo) && sz[i] != 13'h0) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : first_from

    // Walk areas in order, each from its start across size addresses in steps of step
    always_comb begin
        d = q;
        if (sp.restart) begin
            d.idx = first_from(4'h0, sp.size);
            d.off = 13'h0;
        end else if (sp.adv && q.idx != AREA_NONE) begin
            if (13'(q.off + {11'h0, sp.step}) >= sp.size[q.idx[2:0]]) begin
                d.idx = first_from(4'(q.idx + 4'h1), sp.size);
                d.off = 13'h0;
            end else begin
                d.off = 13'(q.off + {11'h0, sp.step});
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '{idx: AREA_NONE, off: 13'h0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign sp.valid = (q.idx != AREA_NONE);
    assign sp.addr = 13'(sp.start[q.idx[2:0]] + q.off);

    a_addr_in_area: assert property (@(posedge clk) disable iff (!rst_n)
        q.idx != AREA_NONE |-> q.off < sp.size[q.idx[2:0]])
        else $error("walker offset beyond area size");
endmodule : rsr_span_walker
`default_nettype wire

// ### tb/rsr_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsr_rx_model (
    input wire logic pix_clk,
    input wire logic frame_start,
    input wire logic frame_invalid,
    input wire logic pix_valid,
    input wire logic [1:0] line_kind,
    input wire logic [12:0] pix_col,
    input wire logic [12:0] pix_row,
    output logic vertical_sync_input,
    output int n_frames,
    output int n_inv,
    output logic [12:0] first_col,
    output logic [12:0] first_row
);
    logic got, inv_q;
    // Master mode only, so the sync pin stays quiet
    initial begin
        vertical_sync_input = 1'b0;
        n_frames = 0;
        n_inv = 0;
        got = 1'b0;
        inv_q = 1'b0;
    end
    // Count frames and invalid frames, keep first image pixel of each frame
    always @(posedge pix_clk) begin
        inv_q <= frame_invalid;
        if (frame_invalid === 1'b1 && inv_q !== 1'b1) begin
            n_inv <= n_inv + 1;
        end
        if (frame_start === 1'b1) begin
            n_frames <= n_frames + 1;
            got <= 1'b0;
        end else if (pix_valid === 1'b1 && line_kind === 2'h3 && !got) begin
            got <= 1'b1;
            first_col <= pix_col;
            first_row <= pix_row;
        end
    end
endmodule : rsr_rx_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rsr_pkg::*;
    logic core_clk = 0, pix_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, sum;
    logic pready, pslverr, er, fv, lv, pv, finv, fst, vsync;
    logic [1:0] kind;
    logic [12:0] col, row, fc, fr;
    int n_fail = 0, tests_run = 0, seed = 22, nf, ni, k0, s, hs, vs;
    logic [9:0] ri [10] = '{IDX_CROP_EN, IDX_TUNE[0], IDX_DECIM, IDX_OBW, IDX_FIW,
                            IDX_FRAME_LINE_TOTAL, IDX_LINE_CLOCK_TOTAL, IDX_RATE, IDX_RWT, IDX_TWT};
    logic [31:0] rv [10] = '{32'h0, 32'h0A, 32'h0, 32'h9A8, 32'h9A8,
                             32'h8AA, 32'h167, 32'h2, 32'h06, 32'h28};
    // Core clock, link clock offset so the phases never line up
    always #5 core_clk = ~core_clk;
    always #16 pix_clk = ~pix_clk;
    rsr_readout dut_u (.core_clk(core_clk), .resetn(resetn), .core_ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_clk(pix_clk),
        .vertical_sync_input(vsync), .frame_valid(fv), .line_valid(lv), .pix_valid(pv),
        .line_kind(kind), .pix_col(col), .pix_row(row), .frame_invalid(finv),
        .frame_start(fst));
    rsr_rx_model rx_u (.pix_clk(pix_clk), .frame_start(fst), .frame_invalid(finv),
        .pix_valid(pv), .line_kind(kind), .pix_col(col), .pix_row(row),
        .vertical_sync_input(vsync), .n_frames(nf), .n_inv(ni), .first_col(fc),
        .first_row(fr));
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
        int t;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (t = 0; t < 16; t++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (t == 16) begin
            n_fail++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Bounded wait for k more frame starts
    task wf(input int k);
        int t;
        k0 = nf + k;
        for (t = 0; t < 9000 * k && nf < k0; t++) @(posedge core_clk);
        if (nf < k0) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : wf
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        for (int j = 0; j < 10; j++) begin
            apb(1'b0, ri[j], 32'h0);
            chk(rd, rv[j]);
        end
        apb(1'b0, 10'h0FF, 32'h0);
        chk(32'(er), 32'h1);
        s = 32'h10 + ($random(seed) & 32'h7F8);
        apb(1'b1, IDX_OBW, s);
        apb(1'b0, IDX_OBW, 32'h0);
        chk(rd, s);
        s = 32'h4B0 + ($random(seed) & 32'h3F0);
        apb(1'b1, IDX_FIW, s);
        apb(1'b0, IDX_FIW, 32'h0);
        chk(rd, s);
        $display("register test done");
        // Short frames: no shutter waits, 12-clock lines, 128 lines
        apb(1'b1, IDX_RWT, 32'h0);
        apb(1'b1, IDX_TWT, 32'h0);
        apb(1'b1, IDX_LINE_CLOCK_TOTAL, 32'h0C);
        apb(1'b1, IDX_FRAME_LINE_TOTAL, 32'h80);
        wf(3);
        chk(32'(fc), 32'h0);
        chk(32'(fr), 32'h0);
        $display("full scan test done");
        hs = $random(seed) & 32'h78;
        vs = $random(seed) & 32'h78;
        s = ni;
        apb(1'b1, 10'(IDX_AREA_BASE + F_HS), hs);
        apb(1'b1, 10'(IDX_AREA_BASE + F_HZ), 32'h4B0);
        apb(1'b1, 10'(IDX_AREA_BASE + F_VS), vs);
        apb(1'b1, 10'(IDX_AREA_BASE + F_VZ), 32'h8);
        apb(1'b1, IDX_CROP_EN, 32'h1);
        wf(5);
        chk(ni - s, 32'h1);
        chk(32'(fc), hs);
        chk(32'(fr), vs);
        $display("crop test done");
        // Crop off before subsampling; tune byte as for a 37.125 MHz input clock
        apb(1'b1, IDX_CROP_EN, 32'h0);
        apb(1'b1, IDX_TUNE[0], 32'h05);
        apb(1'b0, IDX_TUNE[0], 32'h0);
        chk(rd, 32'h05);
        apb(1'b1, IDX_DECIM, 32'h1);
        wf(3);
        chk(32'(fc), 32'h0);
        chk(32'(fr), 32'h1);
        $display("subsample test done");
        sum = 32'h8;
        for (int a = 1; a < 8; a++) begin
            s = 32'h8 + ($random(seed) & 32'h38);
            sum = sum + s;
            apb(1'b1, 10'(IDX_AREA_BASE + 4 * a + F_HZ), 32'h8);
            apb(1'b1, 10'(IDX_AREA_BASE + 4 * a + F_VZ), s);
        end
        wf(3);
        apb(1'b0, IDX_LPF, 32'h0);
        chk(rd, sum + 32'(FIXED_LINES) + 32'(RST_SETTLE));
        $display("line count test done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
